// ### rtl/ebst_ctrl.v
// Behaviour
// - space 1 prefetch shortens sequential accesses
// - shortening only for next sequential address
// - space 1 write precharge inserts one idle
// - space 1 read precharge inserts one idle
// - space 1 external wait extends while low
// - space 1 burst wait count, zero skips sampling
// - space 1 normal wait count, zero skips sampling
// - space 1 burst length boundary selection
// - space 1 bus width 16 or 8
// - space 2 prefetch shortening
// - space 2 write/read precharge idles
// - space 2 external wait extends while low
// - space 2 burst length boundary selection
// - space 2 bus width 16 or 8
// - dummy space prefetch shortening
// - dummy write/read precharge idles
// - dummy external wait extends while low
// - dummy burst wait count, zero skips sampling
// - dummy space asserts no chip select
// - dummy normal wait count, zero skips sampling
// - dummy burst length boundary selection
// - dummy bus width 16 or 8
`timescale 1ns/1ps
`include "ebst_defines.vh"

module ebst_ctrl #(
   parameter ADDR_W = 26
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire req_valid,
   output wire req_ready,
   input wire [ADDR_W-1:0] req_addr,
   input wire req_write,
   input wire [15:0] req_wdata,
   output reg rsp_valid,
   output reg [15:0] rsp_rdata,
   output reg [ADDR_W-3:0] ext_addr,
   output reg [2:0] ext_cs_n,
   output reg ext_rd_n,
   output reg ext_wr_n,
   output reg [15:0] ext_data_out,
   output reg ext_data_oe,
   input wire [15:0] ext_data_in,
   input wire ext_wait_n
);

   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_SETUP = 5'b00010;
   localparam [4:0] ST_WAIT = 5'b00100;
   localparam [4:0] ST_XFER = 5'b01000;
   localparam [4:0] ST_PRE = 5'b10000;
   localparam [31:0] CFG_RST = `EBST_CFG_RESET;

   reg [31:0] cfg0_reg;
   reg [31:0] cfg1_reg;
   reg aw_held_reg;
   reg [7:0] aw_addr_reg;
   reg w_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   wire [31:0] stat_word;
   reg [15:0] access_count_reg;

   assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   wire wr_cfg0 = wr_fire & (aw_addr_reg == `EBST_OFS_CFG0);
   wire wr_cfg1 = wr_fire & (aw_addr_reg == `EBST_OFS_CFG1);
   wire wr_stat = wr_fire & (aw_addr_reg == `EBST_OFS_STAT);

   // address and data may arrive in either order; hold each until both are in
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EBST_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_cfg0 | wr_cfg1 | wr_stat) ? `EBST_RESP_OKAY : `EBST_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // config words with byte enables; an access already running keeps its snapshot
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
         always @(posedge aclk) begin
            if (!aresetn) begin
               cfg0_reg[gb*8+7:gb*8] <= CFG_RST[gb*8 +: 8];
               cfg1_reg[gb*8+7:gb*8] <= CFG_RST[gb*8 +: 8];
            end else begin
               if (wr_cfg0 && w_strb_reg[gb]) begin
                  cfg0_reg[gb*8+7:gb*8] <= w_data_reg[gb*8+7:gb*8];
               end
               if (wr_cfg1 && w_strb_reg[gb]) begin
                  cfg1_reg[gb*8+7:gb*8] <= w_data_reg[gb*8+7:gb*8];
               end
            end
         end
      end
   endgenerate

   // read side: config words are write-only and read back as zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `EBST_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case ({s_axi_araddr[7:2], 2'b00})
            `EBST_OFS_CFG0, `EBST_OFS_CFG1: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `EBST_RESP_OKAY;
            end
            `EBST_OFS_STAT: begin
               s_axi_rdata <= stat_word;
               s_axi_rresp <= `EBST_RESP_OKAY;
            end
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `EBST_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   reg wait_s1_reg;
   reg wait_s2_reg;
   reg [15:0] din_s1_reg;
   reg [15:0] din_s2_reg;

   // wait and data pins are asynchronous to aclk
   always @(posedge aclk) begin
      if (!aresetn) begin
         wait_s1_reg <= 1'b1;
         wait_s2_reg <= 1'b1;
         din_s1_reg <= 16'h0000;
         din_s2_reg <= 16'h0000;
      end else begin
         wait_s1_reg <= ext_wait_n;
         wait_s2_reg <= wait_s1_reg;
         din_s1_reg <= ext_data_in;
         din_s2_reg <= din_s1_reg;
      end
   end

   wire [1:0] req_space = req_addr[ADDR_W-1:ADDR_W-2];
   wire sel_pref;
   wire sel_wpc;
   wire sel_rpc;
   wire sel_ewt;
   wire [3:0] sel_bw;
   wire [3:0] sel_nw;
   wire [1:0] sel_ln;
   wire sel_byte;
   wire [2:0] sel_cs;

   // live lookup of the requested space, frozen into the snapshot at start
   ebst_space_sel u_sel (
      .cfg0(cfg0_reg),
      .cfg1(cfg1_reg),
      .space(req_space),
      .pref(sel_pref),
      .wpc(sel_wpc),
      .rpc(sel_rpc),
      .ewt(sel_ewt),
      .burst_wait(sel_bw),
      .normal_wait(sel_nw),
      .burst_len(sel_ln),
      .byte_bus(sel_byte),
      .cs_sel(sel_cs)
   );

   reg [4:0] state_reg;
   reg [4:0] state_next;
   reg [3:0] wcnt_reg;
   reg [1:0] xcnt_reg;
   reg write_reg;
   reg ewt_reg;
   reg pre_reg;
   reg byte_reg;
   reg wsample_reg;
   reg [15:0] wdata_reg;
   reg have_last_reg;
   reg [ADDR_W-1:0] last_addr_reg;
   reg last_write_reg;
   reg last_burst_reg;
   reg last_pref_reg;
   reg [1:0] last_space_reg;

   // address of the next item; an 8-bit bus steps by one, a 16-bit bus by two
   wire [ADDR_W-1:0] step = sel_byte ? {{(ADDR_W-1){1'b0}}, 1'b1} : {{(ADDR_W-2){1'b0}}, 2'b10};
   wire [ADDR_W-1:0] next_addr = last_addr_reg + step;
   wire seq_hit = have_last_reg & (req_addr == next_addr) & (req_space == last_space_reg);
   wire [ADDR_W-1:0] beat_cur = sel_byte ? req_addr : {1'b0, req_addr[ADDR_W-1:1]};
   wire [ADDR_W-1:0] beat_last = sel_byte ? last_addr_reg : {1'b0, last_addr_reg[ADDR_W-1:1]};
   reg in_bound;

   // boundary check of a burst continuation
   always @* begin
      case (sel_ln)
         `EBST_LN_B4: in_bound = (beat_cur[ADDR_W-1:2] == beat_last[ADDR_W-1:2]);
         `EBST_LN_B256: in_bound = (beat_cur[ADDR_W-1:8] == beat_last[ADDR_W-1:8]);
         `EBST_LN_FREE: in_bound = 1'b1;
         default: in_bound = 1'b0;
      endcase
   end

   wire start = req_valid & req_ready;
   wire is_burst = seq_hit & in_bound & (req_write == last_write_reg);
   wire use_pref = sel_pref & seq_hit;
   wire [3:0] start_wait = is_burst ? sel_bw : sel_nw;
   wire wait_done = (wcnt_reg == 4'h0) & ~(ewt_reg & wsample_reg & ~wait_s2_reg);
   wire xfer_done = write_reg | (xcnt_reg == 2'h0);

   assign req_ready = state_reg[0];

   // state sequencing
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               // prefetch removes the setup cycle on the next sequential item
               state_next = use_pref ? ST_WAIT : ST_SETUP;
            end
         end
         ST_SETUP: state_next = ST_WAIT;
         ST_WAIT: state_next = wait_done ? ST_XFER : ST_WAIT;
         ST_XFER: state_next = xfer_done ? (pre_reg ? ST_PRE : ST_IDLE) : ST_XFER;
         ST_PRE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // snapshot of the target space settings plus counters
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         wcnt_reg <= 4'h0;
         xcnt_reg <= 2'h0;
         write_reg <= 1'b0;
         ewt_reg <= 1'b0;
         pre_reg <= 1'b0;
         byte_reg <= 1'b0;
         wsample_reg <= 1'b0;
         wdata_reg <= 16'h0000;
         have_last_reg <= 1'b0;
         last_addr_reg <= {ADDR_W{1'b0}};
         last_write_reg <= 1'b0;
         last_burst_reg <= 1'b0;
         last_pref_reg <= 1'b0;
         last_space_reg <= 2'b00;
         access_count_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         if (start) begin
            write_reg <= req_write;
            wcnt_reg <= start_wait;
            wsample_reg <= (start_wait != 4'h0);
            ewt_reg <= sel_ewt;
            pre_reg <= req_write ? sel_wpc : sel_rpc;
            byte_reg <= sel_byte;
            wdata_reg <= sel_byte ? {8'h00, req_wdata[7:0]} : req_wdata;
            xcnt_reg <= `EBST_RD_HOLD;
            have_last_reg <= 1'b1;
            last_addr_reg <= req_addr;
            last_write_reg <= req_write;
            last_burst_reg <= is_burst;
            last_pref_reg <= use_pref;
            last_space_reg <= req_space;
            access_count_reg <= access_count_reg + 16'h0001;
         end else if (state_reg == ST_WAIT && wcnt_reg != 4'h0) begin
            wcnt_reg <= wcnt_reg - 4'h1;
         end else if (state_reg == ST_XFER && xcnt_reg != 2'h0) begin
            xcnt_reg <= xcnt_reg - 2'h1;
         end
      end
   end

   // bus pins and the answer to the requester
   always @(posedge aclk) begin
      if (!aresetn) begin
         ext_addr <= {(ADDR_W-2){1'b0}};
         ext_cs_n <= 3'b111;
         ext_rd_n <= 1'b1;
         ext_wr_n <= 1'b1;
         ext_data_out <= 16'h0000;
         ext_data_oe <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
      end else begin
         rsp_valid <= 1'b0;
         if (start) begin
            ext_addr <= req_addr[ADDR_W-3:0];
            ext_cs_n <= ~sel_cs;
            ext_data_out <= sel_byte ? {8'h00, req_wdata[7:0]} : req_wdata;
            ext_data_oe <= req_write;
            ext_rd_n <= ~(use_pref & ~req_write);
            ext_wr_n <= ~(use_pref & req_write);
         end else if (state_reg == ST_SETUP) begin
            ext_rd_n <= write_reg;
            ext_wr_n <= ~write_reg;
         end else if (state_reg == ST_XFER && xfer_done) begin
            // release chip select, strobes and data drive; precharge simply leaves the bus idle a cycle
            ext_cs_n <= 3'b111;
            ext_rd_n <= 1'b1;
            ext_wr_n <= 1'b1;
            ext_data_oe <= 1'b0;
            rsp_valid <= 1'b1;
            if (!write_reg)
               rsp_rdata <= byte_reg ? {8'h00, din_s2_reg[7:0]} : din_s2_reg;
         end
      end
   end

   // status word shows the engine's own state
   assign stat_word = {access_count_reg, 8'h00, last_space_reg, last_pref_reg, last_burst_reg,
                       have_last_reg, byte_reg, ext_data_oe, ~state_reg[0]};

endmodule

// ### rtl/ebst_defines.vh
`ifndef EBST_DEFINES_VH
`define EBST_DEFINES_VH

// register byte offsets on the AXI4-Lite port
`define EBST_OFS_CFG0 8'h00
`define EBST_OFS_CFG1 8'h04
`define EBST_OFS_STAT 8'h08
`define EBST_CFG_RESET 32'h00000000

// space01_access_config: space 1 fields
`define EBST_S1_PREF 15
`define EBST_S1_WPC 14
`define EBST_S1_RPC 13
`define EBST_S1_EWT 12
`define EBST_S1_BW_MSB 11
`define EBST_S1_BW_LSB 8
`define EBST_S1_NW_MSB 7
`define EBST_S1_NW_LSB 4
`define EBST_S1_LN_MSB 3
`define EBST_S1_LN_LSB 2
`define EBST_S1_SZ 0

// space2_dummy_access_config: space 2 fields
`define EBST_S2_PREF 31
`define EBST_S2_WPC 30
`define EBST_S2_RPC 29
`define EBST_S2_EWT 28
`define EBST_S2_BW_MSB 27
`define EBST_S2_BW_LSB 24
`define EBST_S2_NW_MSB 23
`define EBST_S2_NW_LSB 20
`define EBST_S2_LN_MSB 19
`define EBST_S2_LN_LSB 18
`define EBST_S2_SZ 16

// space2_dummy_access_config: dummy space fields
`define EBST_DM_PREF 15
`define EBST_DM_WPC 14
`define EBST_DM_RPC 13
`define EBST_DM_EWT 12
`define EBST_DM_BW_MSB 11
`define EBST_DM_BW_LSB 8
`define EBST_DM_NW_MSB 7
`define EBST_DM_NW_LSB 4
`define EBST_DM_LN_MSB 3
`define EBST_DM_LN_LSB 2
`define EBST_DM_SZ 0

// space codes, taken from the top two address bits
`define EBST_SP_CS0 2'b00
`define EBST_SP_CS1 2'b01
`define EBST_SP_CS2 2'b10
`define EBST_SP_DUMMY 2'b11

// burst length codes
`define EBST_LN_NONE 2'b00
`define EBST_LN_B4 2'b01
`define EBST_LN_B256 2'b10
`define EBST_LN_FREE 2'b11

// extra strobe cycles on a read so the synchronised data bus settles
`define EBST_RD_HOLD 2'h2

// axi responses
`define EBST_RESP_OKAY 2'b00
`define EBST_RESP_SLVERR 2'b10

`endif

// ### rtl/ebst_space_sel.v
`timescale 1ns/1ps
`include "ebst_defines.vh"

module ebst_space_sel (
   input wire [31:0] cfg0,
   input wire [31:0] cfg1,
   input wire [1:0] space,
   output reg pref,
   output reg wpc,
   output reg rpc,
   output reg ewt,
   output reg [3:0] burst_wait,
   output reg [3:0] normal_wait,
   output reg [1:0] burst_len,
   output reg byte_bus,
   output reg [2:0] cs_sel
);

   // pick the field set of the decoded space; space 0 keeps all fields at zero and only selects chip select 0
   always @* begin
      pref = 1'b0;
      wpc = 1'b0;
      rpc = 1'b0;
      ewt = 1'b0;
      burst_wait = 4'h0;
      normal_wait = 4'h0;
      burst_len = `EBST_LN_NONE;
      byte_bus = 1'b0;
      cs_sel = 3'b000;
      case (space)
         `EBST_SP_CS1: begin
            pref = cfg0[`EBST_S1_PREF];
            wpc = cfg0[`EBST_S1_WPC];
            rpc = cfg0[`EBST_S1_RPC];
            ewt = cfg0[`EBST_S1_EWT];
            burst_wait = cfg0[`EBST_S1_BW_MSB:`EBST_S1_BW_LSB];
            normal_wait = cfg0[`EBST_S1_NW_MSB:`EBST_S1_NW_LSB];
            burst_len = cfg0[`EBST_S1_LN_MSB:`EBST_S1_LN_LSB];
            byte_bus = cfg0[`EBST_S1_SZ];
            cs_sel = 3'b010;
         end
         `EBST_SP_CS2: begin
            pref = cfg1[`EBST_S2_PREF];
            wpc = cfg1[`EBST_S2_WPC];
            rpc = cfg1[`EBST_S2_RPC];
            ewt = cfg1[`EBST_S2_EWT];
            burst_wait = cfg1[`EBST_S2_BW_MSB:`EBST_S2_BW_LSB];
            normal_wait = cfg1[`EBST_S2_NW_MSB:`EBST_S2_NW_LSB];
            burst_len = cfg1[`EBST_S2_LN_MSB:`EBST_S2_LN_LSB];
            byte_bus = cfg1[`EBST_S2_SZ];
            cs_sel = 3'b100;
         end
         `EBST_SP_DUMMY: begin
            // dummy space drives no chip select
            pref = cfg1[`EBST_DM_PREF];
            wpc = cfg1[`EBST_DM_WPC];
            rpc = cfg1[`EBST_DM_RPC];
            ewt = cfg1[`EBST_DM_EWT];
            burst_wait = cfg1[`EBST_DM_BW_MSB:`EBST_DM_BW_LSB];
            normal_wait = cfg1[`EBST_DM_NW_MSB:`EBST_DM_NW_LSB];
            burst_len = cfg1[`EBST_DM_LN_MSB:`EBST_DM_LN_LSB];
            byte_bus = cfg1[`EBST_DM_SZ];
            cs_sel = 3'b000;
         end
         default: begin
            cs_sel = 3'b001;
         end
      endcase
   end

endmodule

// ### test/ebst_ctrl_sva.sv
`timescale 1ns/1ps
// protocol checks on the block's own ports, clocked by aclk
module ebst_ctrl_sva #(
   parameter ADDR_W = 26
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire req_valid,
   input wire req_ready,
   input wire [ADDR_W-1:0] req_addr,
   input wire req_write,
   input wire rsp_valid,
   input wire [2:0] ext_cs_n,
   input wire ext_rd_n,
   input wire ext_wr_n,
   input wire ext_data_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // request accepted this edge
   wire take = req_valid & req_ready;
   wire [1:0] sp = req_addr[ADDR_W-1 -: 2];
   a_cs_onehot: assert property ($onehot0(~ext_cs_n))
      else $error("several chip selects low");
   a_dummy_no_cs: assert property (take && sp == 2'b11 |=> (ext_cs_n == 3'b111) [*3])
      else $error("chip select low for dummy space");
   a_space_cs: assert property (take && sp != 2'b11 |=> ext_cs_n == ~(3'b001 << $past(sp)))
      else $error("wrong chip select for space");
   a_strobe_excl: assert property (!(!ext_rd_n && !ext_wr_n))
      else $error("read and write strobes together");
   a_wr_drives: assert property (!ext_wr_n |-> ext_data_oe && !req_ready)
      else $error("write strobe without data drive");
   a_rd_released: assert property (!ext_rd_n |-> !ext_data_oe && !req_ready)
      else $error("data driven during read");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   a_ready_back: assert property (rsp_valid |-> ##[0:1] req_ready)
      else $error("ready late after access end");
   a_min_write: assert property (take && req_write |=> (!rsp_valid) [*2])
      else $error("write finished too soon");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   c_dummy: cover property (take && sp == 2'b11);
   c_precharge: cover property (rsp_valid && !req_ready);
   c_read: cover property (!ext_rd_n && !req_write);
endmodule

bind ebst_ctrl ebst_ctrl_sva #(.ADDR_W(ADDR_W)) ebst_ctrl_sva_inst (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .req_valid(req_valid),
   .req_ready(req_ready),
   .req_addr(req_addr),
   .req_write(req_write),
   .rsp_valid(rsp_valid),
   .ext_cs_n(ext_cs_n),
   .ext_rd_n(ext_rd_n),
   .ext_wr_n(ext_wr_n),
   .ext_data_oe(ext_data_oe)
);

// ### test/ebst_ctrl_test.sv
`timescale 1ns/1ps
`include "ebst_defines.vh"
module ebst_ctrl_test;
   typedef struct {
      logic [31:0] c0;
      logic [31:0] c1;
      logic [25:0] a;
      logic w;
      logic [15:0] q;
      int lat;
   } ebst_row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic req_valid = 1'b0;
   logic [25:0] req_addr = 26'h0;
   logic req_write = 1'b0;
   logic [15:0] req_wdata = 16'h0;
   logic [3:0] hold = 4'h0;
   wire awready, wready, bvalid, arready, rvalid, req_ready, rsp_valid;
   wire rd_n, wr_n, oe, wait_n;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] rsp_rdata, dout, din, wr_seen;
   wire [23:0] ext_addr;
   wire [2:0] cs_n;
   int n_errors = 0;
   int comparisons = 0;
   int lat;
   logic [15:0] q;
   logic rdy;
   logic [31:0] d;
   logic [1:0] r;
   // each row follows the one before: sequential and burst hits depend on it
   ebst_row_t rows [13] = '{
      '{32'h0, 32'h0, 26'h1000000, 1'b1, 16'h1234, 4},
      '{32'h30, 32'h0, 26'h1000010, 1'b0, 16'hB6E1, 9},
      '{32'h8030, 32'h0, 26'h1000012, 1'b0, 16'hB6E1, 8},
      '{32'h15C, 32'h0, 26'h1000014, 1'b0, 16'hB6E1, 7},
      '{32'h0, 32'h200000, 26'h2000100, 1'b1, 16'h5A5A, 6},
      '{32'h0, 32'h3040000, 26'h2000102, 1'b1, 16'hC3C3, 7},
      '{32'h0, 32'h40, 26'h3000000, 1'b1, 16'h0F0F, 8},
      '{32'h0, 32'h8041, 26'h3000001, 1'b0, 16'h00E1, 9},
      '{32'h0, 32'h20D, 26'h3000002, 1'b0, 16'h00E1, 8},
      '{32'h24, 32'h0, 26'h1000016, 1'b0, 16'hB6E1, 8},
      '{32'h24, 32'h0, 26'h1000018, 1'b0, 16'hB6E1, 8},
      '{32'h24, 32'h0, 26'h100001A, 1'b0, 16'hB6E1, 6},
      '{32'h8000, 32'h0, 26'h1000040, 1'b0, 16'hB6E1, 6}};

   always #2 aclk = ~aclk;

   ebst_ctrl #(.ADDR_W(26)) ebst_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .req_valid(req_valid),
      .req_ready(req_ready), .req_addr(req_addr), .req_write(req_write),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .ext_addr(ext_addr), .ext_cs_n(cs_n), .ext_rd_n(rd_n), .ext_wr_n(wr_n),
      .ext_data_out(dout), .ext_data_oe(oe), .ext_data_in(din), .ext_wait_n(wait_n));

   ebst_ext_dev ebst_ext_dev_inst (.aclk(aclk), .ext_rd_n(rd_n), .ext_wr_n(wr_n),
      .ext_data_out(dout), .ext_data_oe(oe), .hold(hold), .ext_data_in(din),
      .ext_wait_n(wait_n), .wr_seen(wr_seen));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // address and data offered together, each dropped at its own handshake
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
   endtask

   // n counts cycles from the take edge to the response pulse
   task automatic acc(input logic [25:0] a, input logic w, input logic [15:0] wd,
         output int n, output logic [15:0] rd, output logic ok);
      req_addr <= a;
      req_write <= w;
      req_wdata <= wd;
      req_valid <= 1'b1;
      do @(posedge aclk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (rsp_valid !== 1'b1);
      rd = rsp_rdata;
      ok = req_ready;
   endtask

   task automatic conclude;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("idle pins", 32'hFA, 32'({cs_n, rd_n, wr_n, oe, req_ready, rsp_valid}));
      foreach (rows[i]) begin
         axw(`EBST_OFS_CFG0, rows[i].c0, r);
         axw(`EBST_OFS_CFG1, rows[i].c1, r);
         acc(rows[i].a, rows[i].w, rows[i].q, lat, q, rdy);
         chk("latency", 32'(rows[i].lat), 32'(lat));
         chk("data", 32'(rows[i].q), 32'(rows[i].w ? wr_seen : q));
      end
      $display("test rows done");
      // write precharge then read precharge, each direction both ways
      for (int i = 0; i < 4; i++) begin
         axw(`EBST_OFS_CFG0, (i < 2) ? 32'h4000 : 32'h2000, r);
         acc(26'h1000200 + 26'(i * 16), (i == 0 || i == 2), 16'h0, lat, q, rdy);
         chk("ready at end", 32'(i == 1 || i == 2), 32'(rdy));
      end
      $display("test precharge done");
      hold <= 4'h8;
      axw(`EBST_OFS_CFG0, 32'h1030, r);
      acc(26'h1000300, 1'b0, 16'h0, lat, q, rdy);
      chk("stretched", 32'h11, 32'(lat));
      axw(`EBST_OFS_CFG0, 32'h0030, r);
      acc(26'h1000400, 1'b0, 16'h0, lat, q, rdy);
      chk("wait ignored", 32'h9, 32'(lat));
      axw(`EBST_OFS_CFG0, 32'h1000, r);
      acc(26'h1000500, 1'b0, 16'h0, lat, q, rdy);
      chk("no sampling", 32'h6, 32'(lat));
      hold <= 4'h0;
      $display("test external wait done");
      axr(`EBST_OFS_CFG0, d, r);
      chk("config read", 32'h0, d);
      axr(8'h0C, d, r);
      chk("unmapped read", 32'(`EBST_RESP_SLVERR), 32'(r));
      axw(8'h0C, 32'hFFFFFFFF, r);
      chk("unmapped write", 32'(`EBST_RESP_SLVERR), 32'(r));
      axr(`EBST_OFS_STAT, d, r);
      chk("access count", 32'h14, 32'(d[31:16]));
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(`EBST_OFS_STAT, d, r);
      chk("count after reset", 32'h0, 32'(d[31:16]));
      $display("test registers done");
      conclude();
   end

   // hang guard, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      conclude();
   end
endmodule

// ### test/ebst_ext_dev.sv
`timescale 1ns/1ps
// far-side device: answers strobes, can stretch with its wait line
module ebst_ext_dev #(
   parameter RD_WORD = 16'hB6E1
) (
   input wire aclk,
   input wire ext_rd_n,
   input wire ext_wr_n,
   input wire [15:0] ext_data_out,
   input wire ext_data_oe,
   input wire [3:0] hold,
   output wire [15:0] ext_data_in,
   output wire ext_wait_n,
   output reg [15:0] wr_seen
);
   reg strobe_q = 1'b0;
   reg [3:0] cnt = 4'h0;
   reg [15:0] last_reg = 16'h0000;
   wire strobe = ~ext_rd_n | ~ext_wr_n;
   initial wr_seen = 16'h0000;
   // wait counted from strobe start; pulled up otherwise
   always @(posedge aclk) begin
      strobe_q <= strobe;
      if (strobe & ~strobe_q)
         cnt <= hold;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
      if (~ext_wr_n & ext_data_oe)
         wr_seen <= ext_data_out;
      if (~ext_rd_n)
         last_reg <= RD_WORD;
   end
   assign ext_wait_n = (cnt == 4'h0);
   // released bus shows the inverse, so stale data never matches
   assign ext_data_in = ~ext_rd_n ? RD_WORD : ~last_reg;
endmodule
